// ==== ite_entry.sv ====
// Interrupt and trap entry sequencer of the processor core
`timescale 1ns/1ps
// How it works
// - Maskable pin is active-low level
// - Held-low pin repeats interrupts after service
// - Maskable accepted only with interrupt enable
// - Interrupt, NMI, abort entry clears enable
// - Config bit picks non-vectored or vectored
// - Non-vectored: acknowledge, discard byte, vector 0
// - Vectored: master acknowledge, byte is vector
// - Return from interrupt runs end-of-interrupt cycle
// - Index -16..-1 fetches cascade address
// - Cascaded acknowledge returns unsigned vector
// - Cascaded return: master then cascaded EOI
// - NMI latched on falling edge, unmasked
// - NMI acknowledge at FFFF00, vector 1
// - NMI return issues no special cycle
// - Traps other than trace return to trapping instruction
// - Trap entry keeps interrupt enable
// - Trap causes: slave, privilege, call, etc.
// - Trace enable copied to pending, trap at end
// - Other service precedes single trace trap
// - Priority: traps, abort, NMI, INT, trace
// - Vectored acknowledge reads address FFFE00
// - Status 0100 master, 0101 cascaded
// - Descriptor at base plus four times vector
module ite_entry (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Request pins
  input wire logic i_int_n,
  input wire logic i_nmi_n,
  // Core state and events
  input wire logic i_boundary,
  input wire logic i_instr_start,
  input wire logic i_instr_end,
  input wire logic i_ien,
  input wire logic i_trace_en,
  input wire logic i_vectored,
  input wire logic i_abort,
  input wire logic [6:0] i_trap,
  input wire logic i_return_from_interrupt_instr,
  input wire logic [23:0] i_dispatch_table_base,
  // Bus interface unit
  input wire logic i_bus_done,
  input wire logic [31:0] i_bus_data,
  output ite_pkg::ite_bus_type o_bus,
  // Execution unit
  output ite_pkg::ite_entry_type o_entry,
  output logic o_trace_pending,
  output logic o_busy
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ACK, ST_CFETCH, ST_CACK, ST_EOI, ST_CEOI_F, ST_CEOI
  } ite_state_type;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // ==================================================
  // Pin synchronisers and NMI edge latch
  logic [1:0] int_sync_r;
  logic [1:0] nmi_sync_r;
  logic nmi_prev_r;
  logic nmi_pend_r;
  logic trace_pend_r;
  ite_state_type state_r;
  ite_pkg::ite_src_type src_r;
  logic [7:0] idx_r;
  logic take_nmi;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      int_sync_r <= 2'h3;
      nmi_sync_r <= 2'h3;
      nmi_prev_r <= 1'b1;
    end
    else
    begin
      int_sync_r <= {int_sync_r[0], i_int_n};
      nmi_sync_r <= {nmi_sync_r[0], i_nmi_n};
      nmi_prev_r <= nmi_sync_r[1];
    end
  end

  wire nmi_fall = nmi_prev_r & ~nmi_sync_r[1];

  // Set wins over the clear taken on entry
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      nmi_pend_r <= 1'b0;
    else if (nmi_fall)
      nmi_pend_r <= 1'b1;
    else if (take_nmi)
      nmi_pend_r <= 1'b0;
  end

  // ==================================================
  // Request arbitration at instruction boundaries
  wire idle = (state_r == ST_IDLE);
  wire eval = idle & i_boundary;
  wire int_req = ~int_sync_r[1] & i_ien;
  ite_pkg::ite_src_type win;

  always_comb
  begin
    if (|i_trap)
      win = ite_pkg::SRC_TRAP;
    else if (i_abort)
      win = ite_pkg::SRC_ABORT;
    else if (nmi_pend_r)
      win = ite_pkg::SRC_NMI;
    else if (int_req)
      win = ite_pkg::SRC_INT;
    else if (trace_pend_r & i_instr_end)
      win = ite_pkg::SRC_TRACE;
    else
      win = ite_pkg::SRC_NONE;
  end

  assign take_nmi = eval & (win == ite_pkg::SRC_NMI);

  // Trace pending: loaded at start, consumed only by trace entry
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      trace_pend_r <= 1'b0;
    else if (eval & (win == ite_pkg::SRC_TRACE))
      trace_pend_r <= 1'b0;
    else if (i_instr_start)
      trace_pend_r <= i_trace_en;
  end

  function automatic logic [7:0] trap_vec(input logic [6:0] t);
    if (t[ite_pkg::TR_SLAVE]) return ite_pkg::VEC_SLAVE;
    else if (t[ite_pkg::TR_PRIV]) return ite_pkg::VEC_PRIV;
    else if (t[ite_pkg::TR_SVC]) return ite_pkg::VEC_SVC;
    else if (t[ite_pkg::TR_DVZ]) return ite_pkg::VEC_DVZ;
    else if (t[ite_pkg::TR_FLAG]) return ite_pkg::VEC_FLAG;
    else if (t[ite_pkg::TR_BPT]) return ite_pkg::VEC_BPT;
    else return ite_pkg::VEC_UND;
  endfunction

  function automatic logic [23:0] tab_addr(input logic [23:0] base,
                                           input logic [7:0] ix,
                                           input logic sgn);
    logic [23:0] ext;
    ext = {{16{sgn & ix[7]}}, ix};
    return base + {ext[21:0], 2'b00};
  endfunction

  // ==================================================
  // Entry and bus sequencer
  wire [7:0] rd_byte = i_bus_data[7:0];
  wire rd_neg = rd_byte[7];
  wire rd_casc = rd_neg & (rd_byte >= ite_pkg::CASC_MIN);
  wire [7:0] own_vec = (win == ite_pkg::SRC_TRAP) ? trap_vec(i_trap) :
    (win == ite_pkg::SRC_ABORT) ? ite_pkg::VEC_ABORT : ite_pkg::VEC_TRACE;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_r <= ST_IDLE;
      src_r <= ite_pkg::SRC_NONE;
      idx_r <= 8'h00;
      o_bus <= '0;
      o_entry <= '0;
    end
    else
    begin
      o_entry.valid <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (eval & (win != ite_pkg::SRC_NONE))
          begin
            src_r <= win;
            if (win == ite_pkg::SRC_NMI || win == ite_pkg::SRC_INT)
            begin
              state_r <= ST_ACK;
              o_bus.req <= 1'b1;
              o_bus.status <= ite_pkg::ST_ACK_MASTER;
              if (win == ite_pkg::SRC_INT && i_vectored)
                o_bus.addr <= ite_pkg::VEC_ACK_ADDR;
              else
                o_bus.addr <= ite_pkg::NMI_ACK_ADDR;
            end
            else
            begin
              o_entry.valid <= 1'b1;
              o_entry.src <= win;
              o_entry.ret_next <= (win == ite_pkg::SRC_TRACE);
              o_entry.clr_ien <= (win == ite_pkg::SRC_ABORT);
              o_entry.vector <= own_vec;
              o_entry.desc_addr <= tab_addr(i_dispatch_table_base,
                                            own_vec, 1'b0);
            end
          end
          else if (idle & i_return_from_interrupt_instr)
          begin
            state_r <= ST_EOI;
            o_bus.req <= 1'b1;
            o_bus.addr <= ite_pkg::VEC_ACK_ADDR;
            o_bus.status <= ite_pkg::ST_EOI_MASTER;
          end
        end
        ST_ACK:
        begin
          if (i_bus_done)
          begin
            if (src_r == ite_pkg::SRC_INT && i_vectored && rd_casc)
            begin
              state_r <= ST_CFETCH;
              idx_r <= rd_byte;
              o_bus.addr <= tab_addr(i_dispatch_table_base, rd_byte, 1'b1);
              o_bus.status <= ite_pkg::ST_MEM_READ;
            end
            else
            begin
              state_r <= ST_IDLE;
              o_bus.req <= 1'b0;
              o_entry.valid <= 1'b1;
              o_entry.src <= src_r;
              o_entry.ret_next <= 1'b1;
              o_entry.clr_ien <= 1'b1;
              if (src_r == ite_pkg::SRC_NMI)
                o_entry.vector <= ite_pkg::VEC_NMI;
              else if (!i_vectored)
                o_entry.vector <= ite_pkg::VEC_NONVEC;
              else
                o_entry.vector <= rd_byte;
              o_entry.desc_addr <= tab_addr(i_dispatch_table_base,
                (src_r == ite_pkg::SRC_NMI) ? ite_pkg::VEC_NMI :
                (!i_vectored) ? ite_pkg::VEC_NONVEC : rd_byte,
                1'b0);
            end
          end
        end
        ST_CFETCH, ST_CEOI_F:
        begin
          if (i_bus_done)
          begin
            state_r <= (state_r == ST_CFETCH) ? ST_CACK : ST_CEOI;
            o_bus.addr <= i_bus_data[23:0];
            o_bus.status <= (state_r == ST_CFETCH) ?
              ite_pkg::ST_ACK_CASC : ite_pkg::ST_EOI_CASC;
          end
        end
        ST_CACK:
        begin
          if (i_bus_done)
          begin
            state_r <= ST_IDLE;
            o_bus.req <= 1'b0;
            o_entry.valid <= 1'b1;
            o_entry.src <= ite_pkg::SRC_INT;
            o_entry.vector <= rd_byte;
            o_entry.ret_next <= 1'b1;
            o_entry.clr_ien <= 1'b1;
            o_entry.desc_addr <= tab_addr(i_dispatch_table_base,
                                          rd_byte, 1'b0);
          end
        end
        ST_EOI:
        begin
          if (i_bus_done)
          begin
            if (rd_casc)
            begin
              state_r <= ST_CEOI_F;
              idx_r <= rd_byte;
              o_bus.addr <= tab_addr(i_dispatch_table_base, rd_byte, 1'b1);
              o_bus.status <= ite_pkg::ST_MEM_READ;
            end
            else
            begin
              state_r <= ST_IDLE;
              o_bus.req <= 1'b0;
            end
          end
        end
        ST_CEOI:
        begin
          if (i_bus_done)
          begin
            state_r <= ST_IDLE;
            o_bus.req <= 1'b0;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
          o_bus.req <= 1'b0;
        end
      endcase
    end
  end

  assign o_trace_pending = trace_pend_r;
  assign o_busy = ~idle;

  // ==================================================
  // Checks
  a_nmi_edge_pend: assert property (nmi_fall |=> nmi_pend_r)
    else $error("nmi edge not latched");
  a_int_masked: assert property (!i_ien |-> win != ite_pkg::SRC_INT)
    else $error("masked interrupt accepted");
  a_nmi_vector: assert property (o_entry.valid &&
    o_entry.src == ite_pkg::SRC_NMI |-> o_entry.vector == ite_pkg::VEC_NMI
    && o_entry.clr_ien)
    else $error("nmi vector wrong");
  a_trap_keeps_ien: assert property (o_entry.valid &&
    o_entry.src == ite_pkg::SRC_TRAP |-> !o_entry.clr_ien && !o_entry.ret_next)
    else $error("trap entry flags wrong");
  a_trap_prio: assert property (eval && (|i_trap) |=> o_entry.valid &&
    o_entry.src == ite_pkg::SRC_TRAP)
    else $error("trap lost priority");
  a_ack_status: assert property (state_r == ST_ACK |->
    o_bus.status == ite_pkg::ST_ACK_MASTER)
    else $error("master ack status wrong");
  a_casc_status: assert property (state_r == ST_CACK |->
    o_bus.status == ite_pkg::ST_ACK_CASC)
    else $error("cascaded ack status wrong");
  a_return_from_interrupt_instr_eoi: assert property (idle && !eval && i_return_from_interrupt_instr |=> o_bus.req &&
    o_bus.status == ite_pkg::ST_EOI_MASTER)
    else $error("no end of interrupt cycle");
  a_trace_start: assert property (i_instr_start &&
    !(eval && win == ite_pkg::SRC_TRACE) |=> trace_pend_r == $past(i_trace_en))
    else $error("trace pending not loaded");

endmodule

// ==== ite_pkg.sv ====
// Package for the interrupt and trap entry unit
package ite_pkg;

  // ==================================================
  // Acknowledge addresses and bus status codes
  localparam logic [23:0] NMI_ACK_ADDR = 24'hFFFF00;
  localparam logic [23:0] VEC_ACK_ADDR = 24'hFFFE00;
  localparam logic [3:0] ST_ACK_MASTER = 4'h4;
  localparam logic [3:0] ST_ACK_CASC = 4'h5;
  localparam logic [3:0] ST_EOI_MASTER = 4'h6;
  localparam logic [3:0] ST_EOI_CASC = 4'h7;
  localparam logic [3:0] ST_MEM_READ = 4'h8;

  // ==================================================
  // Vectors
  localparam logic [7:0] VEC_NONVEC = 8'h00;
  localparam logic [7:0] VEC_NMI = 8'h01;
  localparam logic [7:0] VEC_ABORT = 8'h02;
  localparam logic [7:0] VEC_SLAVE = 8'h03;
  localparam logic [7:0] VEC_PRIV = 8'h04;
  localparam logic [7:0] VEC_SVC = 8'h05;
  localparam logic [7:0] VEC_DVZ = 8'h06;
  localparam logic [7:0] VEC_FLAG = 8'h07;
  localparam logic [7:0] VEC_BPT = 8'h08;
  localparam logic [7:0] VEC_TRACE = 8'h09;
  localparam logic [7:0] VEC_UND = 8'h0A;
  localparam logic [7:0] CASC_MIN = 8'hF0;

  // Trap cause bit positions
  localparam int TR_SLAVE = 0;
  localparam int TR_PRIV = 1;
  localparam int TR_SVC = 2;
  localparam int TR_DVZ = 3;
  localparam int TR_FLAG = 4;
  localparam int TR_BPT = 5;
  localparam int TR_UND = 6;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_TRAP, SRC_ABORT, SRC_NMI, SRC_INT, SRC_TRACE
  } ite_src_type;

  // Bus request to the bus interface unit
  typedef struct packed {
    logic req;
    logic [23:0] addr;
    logic [3:0] status;
  } ite_bus_type;

  // Entry report to the execution unit
  typedef struct packed {
    logic valid;
    ite_src_type src;
    logic [7:0] vector;
    logic [23:0] desc_addr;
    logic ret_next;
    logic clr_ien;
  } ite_entry_type;

endpackage

// ==== ite_ipu_model.sv ====
// Behavioural model of master and cascaded interrupt priority units
`timescale 1ns/1ps
module ite_ipu_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Bus from the entry unit
  input ite_pkg::ite_bus_type i_bus,
  // Answers chosen by the bench
  input wire logic [7:0] i_master_byte,
  input wire logic [7:0] i_casc_byte,
  input wire logic [23:0] i_casc_addr,
  input wire logic [1:0] i_wait,
  // Completion
  output logic o_done,
  output logic [31:0] o_data
);
  logic [1:0] cnt_r;

  // ==================================================
  // Answer after i_wait idle cycles, data churns otherwise
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_done <= 1'b0;
      cnt_r <= 2'h0;
      o_data <= 32'h0;
    end
    else if (i_bus.req && !o_done && cnt_r == i_wait)
    begin
      o_done <= 1'b1;
      cnt_r <= 2'h0;
      case (i_bus.status)
        ite_pkg::ST_ACK_MASTER, ite_pkg::ST_EOI_MASTER:
          o_data <= {24'hA5A5A5, i_master_byte};
        ite_pkg::ST_MEM_READ:
          o_data <= {8'h00, i_casc_addr};
        ite_pkg::ST_ACK_CASC, ite_pkg::ST_EOI_CASC:
          o_data <= {24'h5A5A5A, i_casc_byte};
        default:
          o_data <= ~o_data;
      endcase
    end
    else
    begin
      o_done <= 1'b0;
      o_data <= ~o_data;
      if (i_bus.req && !o_done)
        cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule

// ==== ite_entry_tb.sv ====
// Self-checking bench of the interrupt and trap entry unit
`timescale 1ns/1ps
module ite_entry_tb;
  // ==================================================
  // Signals and instances
  logic i_clk, i_rstn, i_int_n, i_nmi_n, i_boundary, i_instr_start;
  logic i_instr_end, i_ien, i_trace_en, i_vectored, i_abort, i_return_from_interrupt_instr;
  logic bus_done, o_trace_pending, o_busy;
  logic [6:0] i_trap;
  logic [31:0] bus_data;
  logic [7:0] mbyte;
  logic [1:0] wait_n;
  logic [27:0] blog[$];
  ite_pkg::ite_bus_type o_bus;
  ite_pkg::ite_entry_type o_entry, ent;
  int n_mismatch = 0;
  int checks_done = 0;
  localparam logic [23:0] BASE = 24'h001000;
  localparam logic [23:0] CADDR = 24'h00F000;
  localparam logic [27:0] ACK_V = 28'h4FFFE00;
  localparam logic [27:0] ACK_N = 28'h4FFFF00;
  localparam logic [27:0] TBL = 28'h8000FC0;
  localparam logic [27:0] ACK_C = 28'h500F000;
  localparam logic [27:0] EOI_M = 28'h6FFFE00;
  localparam logic [27:0] EOI_C = 28'h700F000;

  ite_entry DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_int_n(i_int_n),
    .i_nmi_n(i_nmi_n), .i_boundary(i_boundary),
    .i_instr_start(i_instr_start), .i_instr_end(i_instr_end),
    .i_ien(i_ien), .i_trace_en(i_trace_en), .i_vectored(i_vectored),
    .i_abort(i_abort), .i_trap(i_trap), .i_return_from_interrupt_instr(i_return_from_interrupt_instr),
    .i_dispatch_table_base(BASE), .i_bus_done(bus_done),
    .i_bus_data(bus_data), .o_bus(o_bus), .o_entry(o_entry),
    .o_trace_pending(o_trace_pending), .o_busy(o_busy));
  ite_ipu_model u_ipu (.i_clk(i_clk), .i_rstn(i_rstn), .i_bus(o_bus),
    .i_master_byte(mbyte), .i_casc_byte(8'hFF), .i_casc_addr(CADDR),
    .i_wait(wait_n), .o_done(bus_done), .o_data(bus_data));

  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Record each completed bus cycle as status and address
  always @(posedge i_clk)
    if (o_bus.req === 1'b1 && bus_done === 1'b1)
      blog.push_back({o_bus.status, o_bus.addr});

  // ==================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_entry();
    ent = '0;
    for (int k = 0; k < 60 && ent.valid !== 1'b1; k++)
    begin
      cyc(1);
      if (o_entry.valid === 1'b1)
        ent = o_entry;
    end
    chk("entry_valid", 32'h1, {31'h0, ent.valid});
  endtask

  task automatic chk_entry(input ite_pkg::ite_src_type s,
    input logic [7:0] v, input logic c, input logic r);
    chk("src", {29'h0, s}, {29'h0, ent.src});
    chk("vector", {24'h0, v}, {24'h0, ent.vector});
    chk("desc", {8'h0, BASE + {14'h0, v, 2'h0}}, {8'h0, ent.desc_addr});
    chk("clr_ien", {31'h0, c}, {31'h0, ent.clr_ien});
    chk("ret_next", {31'h0, r}, {31'h0, ent.ret_next});
  endtask

  task automatic chk_bus(input int n, input logic [27:0] e0, e1, e2);
    logic [27:0] e[3];
    e = '{e0, e1, e2};
    chk("bus_count", 32'(n), 32'(blog.size()));
    for (int i = 0; i < n && i < blog.size(); i++)
      chk("bus_cycle", {4'h0, e[i]}, {4'h0, blog[i]});
    blog.delete();
  endtask

  task automatic t_int(input logic vec, input logic [7:0] mb,
    input logic [7:0] ev);
    mbyte = mb;
    i_vectored = vec;
    i_ien = 1'b1;
    i_int_n = 1'b0;
    wait_entry();
    i_ien = 1'b0;
    i_int_n = 1'b1;
    cyc(4);
    chk_entry(ite_pkg::SRC_INT, ev, 1'b1, 1'b1);
  endtask

  // ==================================================
  // Scenarios
  task automatic t_nonvec();
    t_int(1'b0, 8'h55, 8'h00);
    chk_bus(1, ACK_N, 0, 0);
  endtask

  task automatic t_repeat();
    t_int(1'b1, 8'h7F, 8'h7F);
    i_ien = 1'b1;
    i_int_n = 1'b0;
    wait_entry();
    i_ien = 1'b0;
    cyc(2);
    i_ien = 1'b1;
    wait_entry();
    i_ien = 1'b0;
    i_int_n = 1'b1;
    cyc(4);
    chk_entry(ite_pkg::SRC_INT, 8'h7F, 1'b1, 1'b1);
    chk_bus(3, ACK_V, ACK_V, ACK_V);
  endtask

  task automatic t_cascade();
    wait_n = 2'h2;
    t_int(1'b1, 8'hF0, 8'hFF);
    chk_bus(3, ACK_V, TBL, ACK_C);
  endtask

  task automatic t_masked();
    i_int_n = 1'b0;
    cyc(10);
    chk("busy", 32'h0, {31'h0, o_busy});
    chk_bus(0, 0, 0, 0);
    i_int_n = 1'b1;
    cyc(4);
  endtask

  task automatic t_return_from_interrupt_instr(input logic [7:0] mb, input int n);
    mbyte = mb;
    i_boundary = 1'b0;
    i_return_from_interrupt_instr = 1'b1;
    cyc(1);
    i_return_from_interrupt_instr = 1'b0;
    i_boundary = 1'b1;
    cyc(16);
    chk_bus(n, EOI_M, TBL, EOI_C);
  endtask

  task automatic t_nmi();
    mbyte = 8'h33;
    i_nmi_n = 1'b0;
    wait_entry();
    chk_entry(ite_pkg::SRC_NMI, 8'h01, 1'b1, 1'b1);
    chk_bus(1, ACK_N, 0, 0);
    cyc(10);
    chk_bus(0, 0, 0, 0);
    i_nmi_n = 1'b1;
    cyc(4);
  endtask

  task automatic t_traps();
    logic [7:0] tv[7];
    tv = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A};
    i_ien = 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      i_trap = 7'h01 << i;
      wait_entry();
      i_trap = 7'h00;
      chk_entry(ite_pkg::SRC_TRAP, tv[i], 1'b0, 1'b0);
      cyc(2);
    end
    chk_bus(0, 0, 0, 0);
  endtask

  task automatic t_prio();
    i_boundary = 1'b0;
    i_trap = 7'h04;
    i_abort = 1'b1;
    i_int_n = 1'b0;
    cyc(6);
    chk("busy", 32'h0, {31'h0, o_busy});
    i_boundary = 1'b1;
    wait_entry();
    i_trap = 7'h00;
    chk_entry(ite_pkg::SRC_TRAP, 8'h05, 1'b0, 1'b0);
    wait_entry();
    i_abort = 1'b0;
    i_ien = 1'b0;
    i_int_n = 1'b1;
    chk_entry(ite_pkg::SRC_ABORT, 8'h02, 1'b1, 1'b0);
    cyc(4);
    chk_bus(0, 0, 0, 0);
  endtask

  task automatic t_trace();
    i_trace_en = 1'b1;
    i_instr_start = 1'b1;
    cyc(1);
    i_instr_start = 1'b0;
    i_trace_en = 1'b0;
    chk("pending", 32'h1, {31'h0, o_trace_pending});
    i_instr_end = 1'b1;
    wait_entry();
    i_instr_end = 1'b0;
    chk_entry(ite_pkg::SRC_TRACE, 8'h09, 1'b0, 1'b1);
    cyc(2);
    chk("pending", 32'h0, {31'h0, o_trace_pending});
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==================================================
  // Main sequence and watchdog
  initial
  begin
    {i_rstn, i_instr_start, i_instr_end, i_ien, i_trace_en} = '0;
    {i_vectored, i_abort, i_return_from_interrupt_instr, i_trap, mbyte, wait_n} = '0;
    {i_int_n, i_nmi_n, i_boundary} = 3'h7;
    cyc(3);
    i_rstn = 1'b1;
    cyc(3);
    t_nonvec();
    t_repeat();
    t_cascade();
    t_masked();
    t_return_from_interrupt_instr(8'hF0, 3);
    t_return_from_interrupt_instr(8'h05, 1);
    t_nmi();
    t_traps();
    t_prio();
    t_trace();
    end_of_test();
  end

  initial
  begin
    #(40 * 4000);
    n_mismatch++;
    end_of_test();
  end
endmodule
